// file: rpd_map.vh
// register map and field positions for the receive-port debug / irq-enable bank
// assumes an 8-bit register access port from the serial control bus slave
`ifndef RPD_MAP_VH
`define RPD_MAP_VH
`define RPD_ADDR_DEBUG      8'hd0
`define RPD_ADDR_ICR_HI     8'hd8
`define RPD_DEBUG_RST       8'h00
`define RPD_ICR_HI_RST      8'h00
`define RPD_BIT_SER_BIST    5
`define RPD_BIT_FORCE_CONT  1
`define RPD_BIT_FORCE_ONE   0
`define RPD_BIT_IE_ENC      2
`define RPD_BIT_IE_SEQ      1
`define RPD_DEBUG_RW_MASK   8'hdf
`define RPD_ICR_HI_RW_MASK  8'h06
`define RPD_KEEP_HI_MSB     7
`define RPD_KEEP_HI_LSB     6
`define RPD_KEEP_LO_MSB     4
`define RPD_KEEP_LO_LSB     2
`define RPD_ICR_RSVD_MSB    7
`define RPD_ICR_RSVD_LSB    3
`define RPD_BIT_ICR_RSVD0   0
`define RPD_RDATA_RST       8'h00
`define RPD_RDATA_UNMAPPED  8'h00
`define RPD_OUT_IDLE        1'b0
`endif

// file: rpd_port_regs.v
// receive-port debug control and high interrupt-enable registers
// assumes register accesses arrive as single-cycle strobes from the control bus slave
`timescale 1ns/1ps
`include "rpd_map.vh"

// How it works
// (RULE1) bit 5 shows remote self-test status
// (RULE2) bit 1 forces continuous back-link errors
// (RULE3) bit 0 injects one error, self-clears
// (RULE4) bit 2 enables encoding error interrupt
// (RULE5) bit 1 enables sequence error interrupt
// (RULE6) cleared enables block interrupts; flags unaffected
module rpd_port_regs (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire       remote_selftest_active_i,
  input  wire       encoding_error_flag_i,
  input  wire       ctrl_channel_sequence_flag_i,
  output reg  [7:0] reg_rdata_o,
  output reg        backlink_corrupt_o,
  output reg        encoding_error_irq_o,
  output reg        ctrl_channel_sequence_irq_o
);

  localparam       NUM_IRQ   = 2;
  localparam       IRQ_ENC   = 0;
  localparam       IRQ_SEQ   = 1;
  localparam [7:0] DEBUG_RST = `RPD_DEBUG_RST;
  localparam [7:0] ICR_RST   = `RPD_ICR_HI_RST;
  localparam [7:0] RDATA_RST = `RPD_RDATA_RST;

  // address decode
  wire               hit_debug;
  wire               hit_icr;
  wire               wr_debug;
  wire               wr_icr;

  // write data split into the fields it feeds
  wire [1:0]         wdata_keep_hi;
  wire [2:0]         wdata_keep_lo;
  wire               wdata_cont;
  wire               wdata_one;
  wire               wdata_ie_enc;
  wire               wdata_ie_seq;

  // debug register fields
  reg  [1:0]         keep_hi_reg;
  reg  [1:0]         keep_hi_next;
  reg  [2:0]         keep_lo_reg;
  reg  [2:0]         keep_lo_next;
  reg                cont_reg;
  reg                cont_next;
  reg                one_reg;
  reg                one_next;
  reg                bist_reg;
  reg                bist_next;
  wire [7:0]         debug_view;

  // interrupt enables
  reg                ie_enc_reg;
  reg                ie_enc_next;
  reg                ie_seq_reg;
  reg                ie_seq_next;
  wire [7:0]         icr_view;

  // interrupt gating and output paths
  wire [NUM_IRQ-1:0] irq_flag;
  wire [NUM_IRQ-1:0] irq_enable;
  wire [NUM_IRQ-1:0] irq_next;
  reg  [7:0]         rdata_next;
  reg                corrupt_next;

  assign hit_debug = (reg_addr_i == `RPD_ADDR_DEBUG);
  assign hit_icr   = (reg_addr_i == `RPD_ADDR_ICR_HI);
  assign wr_debug  = reg_wr_i & hit_debug;
  assign wr_icr    = reg_wr_i & hit_icr;

  assign wdata_keep_hi = reg_wdata_i[`RPD_KEEP_HI_MSB:`RPD_KEEP_HI_LSB];
  assign wdata_keep_lo = reg_wdata_i[`RPD_KEEP_LO_MSB:`RPD_KEEP_LO_LSB];
  assign wdata_cont    = reg_wdata_i[`RPD_BIT_FORCE_CONT];
  assign wdata_one     = reg_wdata_i[`RPD_BIT_FORCE_ONE];
  assign wdata_ie_enc  = reg_wdata_i[`RPD_BIT_IE_ENC];
  assign wdata_ie_seq  = reg_wdata_i[`RPD_BIT_IE_SEQ];

  // plain storage bits, no function behind them
  always @* begin
    keep_hi_next = keep_hi_reg;
    keep_lo_next = keep_lo_reg;
    if (wr_debug) begin
      keep_hi_next = wdata_keep_hi;
      keep_lo_next = wdata_keep_lo;
    end
  end

  always @* begin
    cont_next = cont_reg;
    if (wr_debug) begin
      cont_next = wdata_cont; // [RULE2]
    end
  end

  // one-shot lives one cycle, so one error goes out (two at worst at a frame edge)
  always @* begin
    one_next = DEBUG_RST[`RPD_BIT_FORCE_ONE]; // [RULE3]
    if (wr_debug) begin
      one_next = wdata_one; // [RULE3]
    end
  end

  // status bit mirrors the remote; software writes to it are dropped
  always @* begin
    bist_next = remote_selftest_active_i; // [RULE1]
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      keep_hi_reg <= DEBUG_RST[`RPD_KEEP_HI_MSB:`RPD_KEEP_HI_LSB];
      keep_lo_reg <= DEBUG_RST[`RPD_KEEP_LO_MSB:`RPD_KEEP_LO_LSB];
      cont_reg    <= DEBUG_RST[`RPD_BIT_FORCE_CONT];
      one_reg     <= DEBUG_RST[`RPD_BIT_FORCE_ONE];
      bist_reg    <= DEBUG_RST[`RPD_BIT_SER_BIST];
    end else begin
      keep_hi_reg <= keep_hi_next;
      keep_lo_reg <= keep_lo_next;
      cont_reg    <= cont_next;
      one_reg     <= one_next;
      bist_reg    <= bist_next;
    end
  end

  assign debug_view[`RPD_KEEP_HI_MSB:`RPD_KEEP_HI_LSB] = keep_hi_reg;
  assign debug_view[`RPD_BIT_SER_BIST]                 = bist_reg;
  assign debug_view[`RPD_KEEP_LO_MSB:`RPD_KEEP_LO_LSB] = keep_lo_reg;
  assign debug_view[`RPD_BIT_FORCE_CONT]               = cont_reg;
  assign debug_view[`RPD_BIT_FORCE_ONE]                = one_reg;

  always @* begin
    ie_enc_next = ie_enc_reg;
    ie_seq_next = ie_seq_reg;
    if (wr_icr) begin
      ie_enc_next = wdata_ie_enc; // [RULE4]
      ie_seq_next = wdata_ie_seq; // [RULE5]
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ie_enc_reg <= ICR_RST[`RPD_BIT_IE_ENC]; // [RULE6]
      ie_seq_reg <= ICR_RST[`RPD_BIT_IE_SEQ]; // [RULE6]
    end else begin
      ie_enc_reg <= ie_enc_next;
      ie_seq_reg <= ie_seq_next;
    end
  end

  // reserved enable bits have no storage and read back as their reset value
  assign icr_view[`RPD_ICR_RSVD_MSB:`RPD_ICR_RSVD_LSB] = ICR_RST[`RPD_ICR_RSVD_MSB:`RPD_ICR_RSVD_LSB];
  assign icr_view[`RPD_BIT_IE_ENC]                     = ie_enc_reg;
  assign icr_view[`RPD_BIT_IE_SEQ]                     = ie_seq_reg;
  assign icr_view[`RPD_BIT_ICR_RSVD0]                  = ICR_RST[`RPD_BIT_ICR_RSVD0];

  assign irq_flag[IRQ_ENC]   = encoding_error_flag_i;
  assign irq_flag[IRQ_SEQ]   = ctrl_channel_sequence_flag_i;
  assign irq_enable[IRQ_ENC] = ie_enc_reg;
  assign irq_enable[IRQ_SEQ] = ie_seq_reg;

  // gate is unlatched: the status flags already hold the event, so no clear path here
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi = gi + 1) begin : g_irq
      assign irq_next[gi] = irq_flag[gi] & irq_enable[gi]; // [RULE4] [RULE5] [RULE6]
    end
  endgenerate

  // continuous mode holds corruption; one-shot gives a single cycle
  always @* begin
    corrupt_next = cont_reg | one_reg; // [RULE2] [RULE3]
  end

  // unmapped addresses read as zero
  always @* begin
    rdata_next = `RPD_RDATA_UNMAPPED;
    if (hit_debug) begin
      rdata_next = debug_view;
    end else if (hit_icr) begin
      rdata_next = icr_view;
    end
  end

  // read data holds until the next read strobe
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= RDATA_RST;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      backlink_corrupt_o <= `RPD_OUT_IDLE;
    end else begin
      backlink_corrupt_o <= corrupt_next;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      encoding_error_irq_o        <= `RPD_OUT_IDLE;
      ctrl_channel_sequence_irq_o <= `RPD_OUT_IDLE;
    end else begin
      encoding_error_irq_o        <= irq_next[IRQ_ENC];
      ctrl_channel_sequence_irq_o <= irq_next[IRQ_SEQ];
    end
  end

endmodule

// file: rpd_ser_model.sv
// remote serializer stub: reports its self-test state
// bench drives bist_i
`timescale 1ns/1ps
module rpd_ser_model(input wire clk_i, input wire bist_i, output reg selftest_o = 1'b0);
  always @(negedge clk_i) selftest_o <= bist_i;
endmodule

// file: rpd_chk.sv
// assertions on the bank ports
// one clock, sync active-low reset
`timescale 1ns/1ps
module rpd_chk(input wire clk_i, nrst_i, reg_wr_i, reg_rd_i, remote_selftest_active_i, encoding_error_flag_i,
  ctrl_channel_sequence_flag_i, backlink_corrupt_o, encoding_error_irq_o, ctrl_channel_sequence_irq_o,
  input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire dbg_wr = reg_wr_i && reg_addr_i == 8'hd0;
  sequence s_pulse; backlink_corrupt_o ##1 !backlink_corrupt_o; endsequence
  one_shot_a: assert property (dbg_wr && reg_wdata_i[1:0] == 2'h1 |-> ##2 s_pulse) else $error("pulse");
  cont_hold_a: assert property (dbg_wr && reg_wdata_i[1] |-> ##2 backlink_corrupt_o[*2]) else $error("cont");
  cont_stop_a: assert property (dbg_wr && reg_wdata_i[1:0] == 2'h0 |-> ##2 !backlink_corrupt_o) else $error("stop");
  selftest_bit_a: assert property (reg_rd_i && reg_addr_i == 8'hd0 |=>
    reg_rdata_o[5] == $past(remote_selftest_active_i, 2)) else $error("bit5");
  enc_irq_a: assert property (encoding_error_irq_o |-> $past(encoding_error_flag_i)) else $error("enc");
  seq_irq_a: assert property (ctrl_channel_sequence_irq_o |-> $past(ctrl_channel_sequence_flag_i)) else $error("seq");
  reset_irq_a: assert property ($rose(nrst_i) |-> !encoding_error_irq_o && !ctrl_channel_sequence_irq_o) else $error("rst");
endmodule
bind rpd_port_regs rpd_chk u_rpd_chk(.*);

// file: rpd_port_regs_tb.sv
// bench for rpd_port_regs: register access and error injection
// 10 MHz clock, reset held 6 cycles
`timescale 1ns/1ps
module rpd_port_regs_tb;
  reg clk_i = 0, nrst_i = 0, wr = 0, rd = 0, bist = 0, enc = 0, seq = 0;
  reg [7:0] addr = 0, wd = 0;
  wire [7:0] rdata;
  wire st, bc, ei, si;
  int fail_count = 0, num_checks = 0;
  always #50 clk_i = ~clk_i;
  rpd_ser_model u_rpd_ser_model(.clk_i(clk_i), .bist_i(bist), .selftest_o(st));
  rpd_port_regs u_rpd_port_regs(.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .remote_selftest_active_i(st), .encoding_error_flag_i(enc), .ctrl_channel_sequence_flag_i(seq),
    .reg_rdata_o(rdata), .backlink_corrupt_o(bc), .encoding_error_irq_o(ei), .ctrl_channel_sequence_irq_o(si));
  task chk(input [7:0] s, e); num_checks++; if (s !== e) begin fail_count++; $display("[ERR] %0t %h/%h", $time, s, e); end endtask
  task w(input [7:0] a, d); @(negedge clk_i) {addr, wd, wr} = {a, d, 1'b1}; @(negedge clk_i) wr = 0; endtask
  task r(input [7:0] a, e); @(negedge clk_i) {addr, rd} = {a, 1'b1}; @(negedge clk_i) rd = 0; chk(rdata, e); endtask
  task report_and_stop; $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED =="); else $display("== FAILED =="); $finish; endtask
  // generous span: the sequence needs well under 100 cycles
  initial begin #200000; fail_count++; report_and_stop; end
  initial begin
    repeat (6) @(negedge clk_i); nrst_i = 1;
    r(8'hd0, 8'h00); r(8'hd8, 8'h00);
    enc = 1; seq = 1; repeat (2) @(negedge clk_i); chk({ei, si}, 0);
    w(8'hd8, 8'hff); w(8'h10, 8'hff); r(8'h10, 0); r(8'hd8, 8'h06); chk({ei, si}, 3);
    enc = 0; w(8'hd8, 8'h02); @(negedge clk_i) chk({ei, si}, 1);
    w(8'hd0, 8'hfc); r(8'hd0, 8'hdc); w(8'hd0, 8'h01);
    @(negedge clk_i) chk(bc, 1); @(negedge clk_i) chk(bc, 0); r(8'hd0, 0);
    w(8'hd0, 8'h02); repeat (3) @(negedge clk_i) chk(bc, 1); w(8'hd0, 0); @(negedge clk_i) chk(bc, 0);
    bist = 1; repeat (2) @(negedge clk_i); r(8'hd0, 8'h20); bist = 0; repeat (2) @(negedge clk_i); r(8'hd0, 0);
    report_and_stop;
  end
endmodule
